/* common/packetizer_pkg.sv */
package packetizer_pkg;
    // Buffer geometry; both depths are fixed here, and the depth sets the
    // counter width.
    localparam int IN_DEPTH = 256;
    localparam int OUT_DEPTH = 64;
    localparam int IN_AW = 8;
    localparam int OUT_AW = 6;
    localparam logic [IN_AW:0] IN_DEPTH_C = 9'h100;
    localparam logic [OUT_AW:0] OUT_DEPTH_C = 7'h40;
    // Free space needed before clear-to-send is driven active again.
    localparam logic [IN_AW:0] CTS_RESUME_FREE = 9'h022;
    // A CTS threshold closer to full than this margin would leave no room for late bytes.
    localparam logic [IN_AW:0] CTS_MIN_MARGIN = 9'h022;
    localparam logic [7:0] MAX_PACKET_LIMIT = 8'hFF;
    // Special characters on the serial input.
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [7:0] CMD_CHAR = 8'h2B;
    localparam logic [1:0] CMD_COUNT = 2'h3;
    localparam logic [1:0] RTS_HANDSHAKE_ON = 2'h2;
    // Frame layout: start, 8 data, stop.
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] STOP_INDEX = 4'h9;
    localparam logic [15:0] BAUD_DEFAULT = 16'h06C8;
    // Register bus map.
    localparam logic [11:0] ADDR_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_TIMING = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IDENT = 12'h00C;
    // Packet idle timeout is counted in serial bit times.
    localparam logic [15:0] TIMEOUT_DEFAULT = 16'h0003;
    localparam logic [7:0] THRESH_DEFAULT = 8'h00;
    localparam logic [7:0] PKT_DEFAULT = 8'h40;
    localparam logic [8:0] FLOW_DEFAULT = 9'h0C0;

    typedef enum {
        MODE_IDLE,
        MODE_INIT,
        MODE_SEND,
        MODE_RECEIVE
    } mode_t;

    // Radio-side handoff: one transmitted byte or one received byte.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

    typedef struct packed {
        logic [7:0] network_id;
        logic [7:0] channel;
        logic [7:0] address;
    } radio_match_t;
endpackage

/* design/serial_host_packetizer.sv */
`timescale 1ns/1ps
module serial_host_packetizer
    import packetizer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_input_line,
    output logic serial_output_line,
    output logic cts_n,
    input wire logic rts_n,
    output byte_beat_t radio_tx,
    output logic radio_init,
    input wire logic radio_tx_ready,
    input wire logic radio_init_done,
    input wire logic radio_rx_active,
    input wire byte_beat_t radio_rx,
    input wire logic radio_rx_end,
    input wire radio_match_t radio_rx_hdr,
    output logic [1:0] mode_state
);
    localparam logic [15:0] IDENT_VALUE = 16'h5A5A; // Arbitrary value.

    // Software settings.
    logic [15:0] serial_baud_setting;
    logic [15:0] packet_idle_timeout;
    logic [7:0] packet_byte_threshold;
    logic [7:0] max_packet_size;
    logic [8:0] flow_threshold_setting;
    logic [1:0] rts_handshake_setting;
    logic soft_flow_enable;
    logic [1:0] parity_setting;
    logic [2:0] radio_rate_setting;
    radio_match_t own_id;

    // Input synchroniser: three stages, change taken when stages 2 and 3
    // agree so a single-cycle glitch never reaches the receiver.
    logic [2:0] rx_sync;
    logic rx_level;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync <= 3'h7;
            rx_level <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], serial_input_line};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_level <= rx_sync[2];
            end
        end
    end

    // Receiver: sample mid-bit, framing per character.
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_done;
    logic [7:0] rx_byte;
    wire [15:0] half_baud = {1'b0, serial_baud_setting[15:1]};
    // The divisor is cycles per bit, so each count runs from divisor-1 to 0.
    wire [15:0] bit_reload = serial_baud_setting - 16'h0001;
    wire rx_tick = (rx_cnt == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_shift <= 8'h00;
            rx_done <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (!rx_level) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= half_baud;
                    rx_bit <= 4'h0;
                end
            end else if (!rx_tick) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= bit_reload;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && rx_level) begin
                    rx_busy <= 1'b0; // False start.
                end else if (rx_bit != 4'h0 && rx_bit <= DATA_BITS) begin
                    rx_shift <= {rx_level, rx_shift[7:1]};
                end else if (rx_bit == STOP_INDEX) begin
                    rx_busy <= 1'b0;
                    rx_done <= rx_level;
                    rx_byte <= rx_shift;
                end
            end
        end
    end

    // Character classes; soft flow characters are consumed, not stored.
    wire is_xon = soft_flow_enable && rx_byte == XON_CHAR;
    wire is_xoff = soft_flow_enable && rx_byte == XOFF_CHAR;
    wire store_char = rx_done && !is_xon && !is_xoff;

    // Input buffer.
    logic [7:0] in_mem [IN_DEPTH];
    logic [IN_AW-1:0] in_wp;
    logic [IN_AW-1:0] in_rp;
    logic [IN_AW:0] in_count;
    logic [7:0] pkt_left;
    logic [1:0] cmd_seen;
    logic trigger_hold;
    mode_t mode;

    wire in_full = (in_count == IN_DEPTH_C);
    wire in_push = store_char && !in_full;
    wire in_pop = (mode == MODE_SEND) && !radio_tx.valid &&
        (in_count != 9'h000) && (pkt_left != 8'h00);
    wire [IN_AW:0] in_free = IN_DEPTH_C - in_count;

    always_ff @(posedge pclk) begin
        if (in_push) begin
            in_mem[in_wp] <= rx_byte;
        end
    end

    // Count of buffered bytes and the pointers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_wp <= '0;
            in_rp <= '0;
            in_count <= '0;
        end else begin
            in_wp <= in_wp + IN_AW'(in_push);
            in_rp <= in_rp + IN_AW'(in_pop);
            in_count <= in_count + (IN_AW + 1)'(in_push) -
                (IN_AW + 1)'(in_pop);
        end
    end

    // Idle gap timer in bit times since the last character.
    logic [15:0] gap_div;
    logic [15:0] gap_bits;
    wire gap_bit = (gap_div == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_div <= 16'h0000;
            gap_bits <= 16'h0000;
        end else if (rx_busy || rx_done) begin
            gap_div <= bit_reload;
            gap_bits <= 16'h0000;
        end else if (gap_bit) begin
            gap_div <= bit_reload;
            if (gap_bits != 16'hFFFF) begin
                gap_bits <= gap_bits + 16'h0001;
            end
        end else begin
            gap_div <= gap_div - 16'h0001;
        end
    end

    // Command sequence detector; three entry characters in a row.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_seen <= 2'h0;
            trigger_hold <= 1'b0;
        end else begin
            // The clear comes first so a sequence completed in the initializer's
            // last cycle still triggers the next packet.
            if (mode == MODE_INIT) begin
                trigger_hold <= 1'b0;
            end
            if (rx_done) begin
                if (rx_byte != CMD_CHAR) begin
                    cmd_seen <= 2'h0;
                end else if (cmd_seen == CMD_COUNT - 2'h1) begin
                    cmd_seen <= 2'h0;
                    trigger_hold <= 1'b1;
                end else begin
                    cmd_seen <= cmd_seen + 2'h1;
                end
            end
        end
    end

    // Transmit triggers.
    wire has_data = (in_count != 9'h000);
    wire thr_hit = (packet_byte_threshold != 8'h00) &&
        (in_count >= {1'b0, packet_byte_threshold});
    wire pk_hit = (in_count >= {1'b0, max_packet_size});
    wire to_hit = (packet_idle_timeout != 16'h0000) && has_data &&
        (gap_bits >= packet_idle_timeout);
    wire tx_trigger = has_data && (thr_hit || pk_hit || to_hit ||
        trigger_hold);

    // Mode sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_IDLE;
            pkt_left <= 8'h00;
            radio_init <= 1'b0;
            radio_tx <= '0;
        end else begin
            if (radio_tx.valid && radio_tx_ready) begin
                radio_tx.valid <= 1'b0;
            end
            case (mode)
                MODE_IDLE: begin
                    if (radio_rx_active) begin
                        mode <= MODE_RECEIVE;
                    end else if (tx_trigger) begin
                        mode <= MODE_INIT;
                        radio_init <= 1'b1;
                    end
                end
                MODE_INIT: begin
                    if (radio_init_done) begin
                        radio_init <= 1'b0;
                        mode <= MODE_SEND;
                        pkt_left <= max_packet_size;
                    end
                end
                MODE_SEND: begin
                    if (in_pop) begin
                        radio_tx <= '{valid: 1'b1, data: in_mem[in_rp]};
                        pkt_left <= pkt_left - 8'h01;
                    end else if (!radio_tx.valid &&
                        (pkt_left == 8'h00 || !has_data)) begin
                        if (has_data) begin
                            pkt_left <= max_packet_size;
                        end else begin
                            mode <= MODE_IDLE;
                        end
                    end
                end
                MODE_RECEIVE: begin
                    if (!radio_rx_active) begin
                        mode <= MODE_IDLE;
                    end
                end
                default: mode <= MODE_IDLE;
            endcase
        end
    end

    // Clear-to-send off at the threshold and back on once below it; the threshold is kept below full.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_n <= 1'b0;
        end else if (in_count >= flow_threshold_setting) begin
            cts_n <= 1'b1;
        end else if (in_free >= CTS_RESUME_FREE) begin
            cts_n <= 1'b0;
        end
    end

    // Output buffer; the header match is decided per byte.
    logic [7:0] out_mem [OUT_DEPTH];
    logic [OUT_AW-1:0] out_wp;
    logic [OUT_AW-1:0] out_rp;
    logic [OUT_AW:0] out_count;
    logic xoff_hold;
    logic [2:0] rts_sync;
    logic rts_level;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;
    wire hdr_match = (radio_rx_hdr == own_id);
    wire out_full = (out_count == OUT_DEPTH_C);
    wire out_push = radio_rx.valid && hdr_match && !out_full;
    wire rts_block = (rts_handshake_setting == RTS_HANDSHAKE_ON) &&
        rts_level;
    wire out_pop = !tx_busy && (out_count != 7'h00) && !rts_block &&
        !xoff_hold;

    always_ff @(posedge pclk) begin
        if (out_push) begin
            out_mem[out_wp] <= radio_rx.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_wp <= '0;
            out_rp <= '0;
            out_count <= '0;
            xoff_hold <= 1'b0;
            rts_sync <= 3'h7;
            rts_level <= 1'b1;
        end else begin
            out_wp <= out_wp + OUT_AW'(out_push);
            out_rp <= out_rp + OUT_AW'(out_pop);
            out_count <= out_count + (OUT_AW + 1)'(out_push) -
                (OUT_AW + 1)'(out_pop);
            rts_sync <= {rts_sync[1:0], rts_n};
            if (rts_sync[1] == rts_sync[2]) begin
                rts_level <= rts_sync[2];
            end
            if (!soft_flow_enable || (rx_done && is_xon)) begin
                xoff_hold <= 1'b0;
            end else if (rx_done && is_xoff) begin
                xoff_hold <= 1'b1;
            end
        end
    end

    // Serial transmitter toward the host.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy <= 1'b0;
            tx_cnt <= 16'h0000;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3FF;
            serial_output_line <= 1'b1;
        end else if (out_pop) begin
            tx_busy <= 1'b1;
            tx_cnt <= bit_reload;
            tx_bit <= 4'h0;
            tx_shift <= {1'b1, out_mem[out_rp], 1'b0};
            serial_output_line <= 1'b0;
        end else if (tx_busy) begin
            if (tx_cnt != 16'h0000) begin
                tx_cnt <= tx_cnt - 16'h0001;
            end else if (tx_bit == STOP_INDEX) begin
                tx_busy <= 1'b0;
                serial_output_line <= 1'b1;
            end else begin
                tx_cnt <= bit_reload;
                tx_bit <= tx_bit + 4'h1;
                tx_shift <= {1'b1, tx_shift[9:1]};
                serial_output_line <= tx_shift[1];
            end
        end
    end

    // APB slave, zero wait states.
    wire wr = psel && penable && pwrite;
    wire [7:0] pk_wr = (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
    wire sel_cfg = (paddr == ADDR_CONFIG);
    wire sel_tim = (paddr == ADDR_TIMING);
    wire sel_sts = (paddr == ADDR_STATUS);
    wire sel_id = (paddr == ADDR_IDENT);
    wire mapped = sel_cfg || sel_tim || sel_sts || sel_id;
    // Rate bits one and zero share the parity field, so only bit two shows.
    wire [31:0] cfg_word = {1'b0, radio_rate_setting[2], parity_setting,
        soft_flow_enable, rts_handshake_setting, flow_threshold_setting,
        max_packet_size, packet_byte_threshold};
    wire [31:0] tim_word = {packet_idle_timeout, serial_baud_setting};
    wire [31:0] sts_word = {6'h00, mode == MODE_RECEIVE, xoff_hold, cts_n,
        out_count, 7'h00, in_count};
    wire [31:0] id_word = {own_id, IDENT_VALUE[7:0]};
    wire [31:0] rd_word = sel_cfg ? cfg_word : sel_tim ? tim_word :
        sel_sts ? sts_word : sel_id ? id_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            packet_byte_threshold <= THRESH_DEFAULT;
            max_packet_size <= PKT_DEFAULT;
            flow_threshold_setting <= FLOW_DEFAULT;
            rts_handshake_setting <= 2'h0;
            soft_flow_enable <= 1'b0;
            parity_setting <= 2'h0;
            radio_rate_setting <= 3'h0;
            packet_idle_timeout <= TIMEOUT_DEFAULT;
            serial_baud_setting <= BAUD_DEFAULT;
            own_id <= '0;
        end else if (wr && sel_cfg) begin
            packet_byte_threshold <= (pwdata[7:0] > pk_wr) ?
                pk_wr : pwdata[7:0];
            max_packet_size <= pk_wr;
            flow_threshold_setting <= (pwdata[24:16] >
                IN_DEPTH_C - CTS_MIN_MARGIN) ?
                IN_DEPTH_C - CTS_MIN_MARGIN : pwdata[24:16];
            rts_handshake_setting <= pwdata[26:25];
            soft_flow_enable <= pwdata[27];
            parity_setting <= pwdata[29:28];
            radio_rate_setting <= pwdata[30:28];
        end else if (wr && sel_tim) begin
            serial_baud_setting <= pwdata[15:0];
            packet_idle_timeout <= pwdata[31:16];
        end else if (wr && sel_id) begin
            own_id <= pwdata[31:8];
        end
    end

    // Registered read data and answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= rd_word;
        end
    end

    // Mode is shown without lag so it lines up with the radio strobes.
    assign mode_state = 2'(mode);
endmodule // serial_host_packetizer

/* tb/host_uart.sv */
`timescale 1ns/1ps
module host_uart #(
    parameter int BIT = 16
) (
    input wire logic pclk,
    input wire logic serial_output_line,
    output logic serial_input_line
);
    // The line idles high outside frames so no false start bit is seen.
    initial serial_input_line = 1'b1;

    // Start low, data least significant bit first, stop high.
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_input_line <= fr[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask

    // Bits are sampled mid-cell; the wait for a start bit is bounded.
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        while (serial_output_line !== 1'b0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge pclk);
            b[i] = serial_output_line;
        end
        repeat (BIT) @(posedge pclk);
        ok = (n < 20000) && (serial_output_line === 1'b1);
    endtask
endmodule // host_uart

/* tb/packetizer_asserts.sv */
`timescale 1ns/1ps
module packetizer_asserts
    import packetizer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire byte_beat_t radio_tx,
    input wire logic radio_tx_ready,
    input wire logic radio_init,
    input wire logic radio_init_done,
    input wire logic [1:0] mode_state
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Register access answers in the cycle after setup, for one cycle only.
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    // Reception ends in idle, never straight into a transmission.
    AST_RX_TO_IDLE: assert property (mode_state == 2'h3 |=>
        (mode_state == 2'h3 || mode_state == 2'h0))
        else $error("receive mode left for a transmit mode");
    // Payload phase is entered only from the initializer.
    AST_SEND_AFTER_INIT: assert property
        ((mode_state == 2'h2 && $past(mode_state) != 2'h2) |->
        $past(mode_state) == 2'h1)
        else $error("payload started without initializer");
    AST_INIT_IN_MODE: assert property (radio_init |-> mode_state == 2'h1)
        else $error("initializer outside its mode");
    AST_INIT_END: assert property ($fell(radio_init) |->
        $past(radio_init_done))
        else $error("initializer dropped before the radio finished it");
    // A byte offered to the radio is held until taken.
    AST_TX_HOLD: assert property (radio_tx.valid && !radio_tx_ready |=>
        radio_tx.valid && $stable(radio_tx.data))
        else $error("radio byte changed before it was taken");
    AST_TX_IN_SEND: assert property (radio_tx.valid |-> mode_state == 2'h2)
        else $error("radio byte offered outside transmit mode");

    COV_RX: cover property (mode_state == 2'h3);
    COV_STALL: cover property (radio_tx.valid && !radio_tx_ready);
    COV_ERR: cover property (pslverr);
endmodule // packetizer_asserts

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
    import packetizer_pkg::*;
;
    localparam logic [15:0] BIT = 16'h0010;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, rdata;
    logic [31:0] rs = 32'hB8ACEEA5;
    logic serial_input_line, serial_output_line, cts_n, rts_n, rerr;
    logic radio_init, radio_tx_ready, radio_init_done;
    logic radio_rx_active, radio_rx_end;
    byte_beat_t radio_tx, radio_rx;
    radio_match_t radio_rx_hdr;
    logic [1:0] mode_state;
    logic [7:0] q[$];
    logic [7:0] txq[$];
    int n_fail, cmp_count;

    serial_host_packetizer dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_input_line(serial_input_line),
        .serial_output_line(serial_output_line), .cts_n(cts_n),
        .rts_n(rts_n), .radio_tx(radio_tx), .radio_init(radio_init),
        .radio_tx_ready(radio_tx_ready),
        .radio_init_done(radio_init_done),
        .radio_rx_active(radio_rx_active), .radio_rx(radio_rx),
        .radio_rx_end(radio_rx_end), .radio_rx_hdr(radio_rx_hdr),
        .mode_state(mode_state));
    host_uart #(.BIT(16)) host (.pclk(pclk),
        .serial_output_line(serial_output_line),
        .serial_input_line(serial_input_line));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] cfg_word(input logic [7:0] thr,
        input logic [7:0] pk, input logic [8:0] ft, input logic [1:0] rt);
        return {5'h00, rt, ft, pk, thr};
    endfunction

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask
    // Request is held until ready is seen at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 50) begin
            @(posedge pclk);
            i++;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 50) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic wait_cond(input logic [1:0] m, input logic is, int n);
        int i;
        i = 0;
        while (((mode_state === m) != is || txq.size() < n) && i < 9000)
        begin
            @(posedge pclk);
            i++;
        end
        if (i == 9000) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic send_rand(input int n);
        logic [7:0] b;
        repeat (n) begin
            b = (seed[7:0] == CMD_CHAR) ? 8'h2A : seed[7:0];
            seed = lfsr(seed);
            q.push_back(b);
            host.send(b);
        end
    endtask
    // Bytes reach the radio whole and in arrival order.
    task automatic check_tx();
        wait_cond(2'h0, 1'b1, q.size());
        while (q.size() > 0 && txq.size() > 0)
            chk(32'(txq.pop_front()), 32'(q.pop_front()));
        q.delete();
        txq.delete();
    endtask
    task automatic rx_beats(input int n, input logic [23:0] hdr);
        repeat (n) begin
            radio_rx_hdr <= radio_match_t'(hdr);
            radio_rx <= '{1'b1, seed[7:0]};
            q.push_back(seed[7:0]);
            seed = lfsr(seed);
            @(posedge pclk);
            radio_rx.valid <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Radio stand-in takes bytes at a random pace so stalls occur too.
    always @(posedge pclk) begin
        rs <= lfsr(rs);
        radio_tx_ready <= rs[0] | rs[3];
        radio_init_done <= radio_init;
        if (radio_tx.valid && radio_tx_ready)
            txq.push_back(radio_tx.data);
    end
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // A hang anywhere ends in the same closing report.
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        end_sim();
    end

    initial begin
        logic [7:0] b;
        logic ok;
        logic [23:0] own;
        seed = 32'h4753115A;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rts_n = 1'b1;
        {radio_rx_active, radio_rx_end, radio_rx, radio_rx_hdr} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(rdata, cfg_word(8'h00, 8'h40, 9'h0C0, 2'h0));
        apb(1'b0, ADDR_TIMING, 32'h0);
        chk(rdata, {TIMEOUT_DEFAULT, BAUD_DEFAULT});
        apb(1'b0, 12'h010, 32'h0);
        chk({rdata[30:0], rerr}, 32'h00000001);
        apb(1'b1, ADDR_TIMING, {16'h0003, BIT});
        apb(1'b1, ADDR_CONFIG, cfg_word(8'h00, 8'h04, 9'h0C0, 2'h0));
        send_rand(6);
        check_tx();
        chk(32'(mode_state), 32'h0);
        send_rand(1);
        check_tx();
        apb(1'b1, ADDR_TIMING, {16'h0000, BIT});
        apb(1'b1, ADDR_CONFIG, cfg_word(8'h02, 8'h04, 9'h0C0, 2'h0));
        send_rand(1);
        repeat (800) @(posedge pclk);
        chk(32'(txq.size()), 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rdata[8:0]), 32'h1);
        send_rand(1);
        check_tx();
        radio_rx_active <= 1'b1;
        send_rand(2);
        repeat (400) @(posedge pclk);
        chk(32'(txq.size()), 32'h0);
        chk(32'(mode_state), 32'h3);
        radio_rx_active <= 1'b0;
        check_tx();
        apb(1'b1, ADDR_CONFIG, cfg_word(8'h00, 8'h08, 9'h004, 2'h0));
        send_rand(4);
        repeat (40) @(posedge pclk);
        chk(32'(cts_n), 32'h1);
        apb(1'b1, ADDR_CONFIG, cfg_word(8'h01, 8'h08, 9'h004, 2'h0));
        check_tx();
        repeat (40) @(posedge pclk);
        chk(32'(cts_n), 32'h0);
        apb(1'b1, ADDR_CONFIG, cfg_word(8'h00, 8'h08, 9'h0C0, 2'h0));
        repeat (3) host.send(CMD_CHAR);
        wait_cond(2'h0, 1'b0, 0);
        wait_cond(2'h0, 1'b1, 0);
        txq.delete();
        apb(1'b0, ADDR_IDENT, 32'h0);
        own = rdata[31:8];
        apb(1'b1, ADDR_CONFIG, cfg_word(8'h00, 8'h08, 9'h0C0, 2'h2));
        rx_beats(3, own);
        rx_beats(2, ~own);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rdata[22:16]), 32'h3);
        rx_beats(70, own);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rdata[22:16]), 32'h40);
        chk(32'(serial_output_line), 32'h1);
        rts_n <= 1'b0;
        host.recv(b, ok);
        chk({23'h0, ok, b}, {23'h0, 1'b1, q[0]});
        end_sim();
    end
endmodule // testbench

bind serial_host_packetizer packetizer_asserts u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .radio_tx(radio_tx),
    .radio_tx_ready(radio_tx_ready), .radio_init(radio_init),
    .radio_init_done(radio_init_done), .mode_state(mode_state));
